// ### design/gpsr_pkg.sv
// Shared constants for the graphics port signal-role logic.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package gpsr_pkg;
    // Grant-type code encodings, valid only while grant is asserted
    localparam logic [2:0] GT_RD_LP = 3'h0;
    localparam logic [2:0] GT_RD_HP = 3'h1;
    localparam logic [2:0] GT_WR_LP = 3'h2;
    localparam logic [2:0] GT_WR_HP = 3'h3;
    localparam logic [2:0] GT_START = 3'h7;
    // Address bit that carries the internal configuration select
    localparam int CFG_SEL_BIT = 16;
    // Data beats per granted write or read block
    localparam int BLOCK_BEATS = 4;
    // Value of command/byte-enable lines during read return
    localparam logic [3:0] CBE_RD_RETURN = 4'h0;
    // Reset values of driven lines
    localparam logic IDLE_HIGH = 1'b1;
    localparam logic [31:0] AD_RST = 32'h0000_0000;
    localparam logic [3:0] CBE_RST = 4'hf;
    localparam logic [2:0] CNT_RST = 3'h0;
    // Main sequencer states, Gray in the listed order
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_REQ = 3'h1,
        ST_ENQ = 3'h3,
        ST_WDAT = 3'h2,
        ST_RDAT = 3'h6
    } gpsr_state_type;
endpackage

// ### design/gpsr_gnt_if.sv
// Decoded grant events between the grant decoder and the sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface gpsr_gnt_if;
    logic gnt_start;
    logic gnt_write;
    logic gnt_read;
    logic gnt_hp;
    modport dec (output gnt_start, output gnt_write, output gnt_read,
        output gnt_hp);
    modport seq (input gnt_start, input gnt_write, input gnt_read,
        input gnt_hp);
endinterface

// ### design/gpsr_gnt_decode.sv
// Grant decoder: turns grant plus grant-type code into one-cycle events.
// Assumes grant and code are synchronous to CLK.
`timescale 1ns/1ps
module gpsr_gnt_decode (
    input wire logic clk,
    input wire logic srst,
    input wire logic gnt_n,
    input wire logic [2:0] grant_type_code,
    gpsr_gnt_if.dec gi
);
    typedef struct packed {
        logic start;
        logic write;
        logic read;
        logic hp;
    } gpsr_dec_type;

    gpsr_dec_type cur_ff, nxt_ff;

    // Code is looked at only under grant; otherwise it is noise
    always_comb
    begin
        nxt_ff = '0;
        if (!gnt_n)
        begin
            unique case (grant_type_code)
                gpsr_pkg::GT_RD_LP: nxt_ff.read = 1'b1;
                gpsr_pkg::GT_RD_HP:
                begin
                    nxt_ff.read = 1'b1;
                    nxt_ff.hp = 1'b1;
                end
                gpsr_pkg::GT_WR_LP: nxt_ff.write = 1'b1;
                gpsr_pkg::GT_WR_HP:
                begin
                    nxt_ff.write = 1'b1;
                    nxt_ff.hp = 1'b1;
                end
                gpsr_pkg::GT_START: nxt_ff.start = 1'b1;
                default: nxt_ff = '0; // Reserved codes are ignored
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            cur_ff <= '0;
        else
            cur_ff <= nxt_ff;
    end

    assign gi.gnt_start = cur_ff.start;
    assign gi.gnt_write = cur_ff.write;
    assign gi.gnt_read = cur_ff.read;
    assign gi.gnt_hp = cur_ff.hp;

    // No event may follow a cycle without grant
    a_no_event_ungranted: assert property (@(posedge clk) disable iff (srst)
        $past(gnt_n) |-> !(gi.gnt_start || gi.gnt_write || gi.gnt_read))
        else $error("grant event without grant");
endmodule

// ### design/gpsr_port_ctrl.sv
// Graphics device side of the port: request, grant use, bus driving,
// error, interrupt and configuration select signalling.
// Assumes all pins are synchronous to CLK; open-drain wires are resolved
// outside from the _OE_N enables.
//
// Functional notes
// - Pipelined ops leave device-select idle; fast-write stall uses it
// - Configuration select produced internally from address bit
// - Error line asserted only if supported, clock-synchronous
// - Assert request before any transaction or request
// - Grant carries grant-type code: read, write, start
// - Enqueue puts port commands on command lines
// - Write data carries valid byte enables
// - Read return: target drives zeros, master ignores
// - Address/data owner always drives parity line
// - Bus lock never used
// - Level shareable interrupts, first then second line
// - Third and fourth interrupt lines never used
// - Graphics side implements PCI target; others optional
`timescale 1ns/1ps
module gpsr_port_ctrl #(
    parameter int TWO_FUNC = 0,
    parameter int BEATS = gpsr_pkg::BLOCK_BEATS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Arbitration
    output logic REQ_N,
    input wire logic GNT_N,
    input wire logic [2:0] GRANT_TYPE_CODE,
    // Address/data, command and parity pins
    input wire logic [31:0] AD_I,
    output logic [31:0] AD_O,
    output logic AD_OE_N,
    output logic [3:0] CBE_O,
    output logic CBE_OE_N,
    output logic PAR_O,
    output logic PAR_OE_N,
    output logic PIPE_N,
    // Fast-write target signalling
    input wire logic FRAME_N,
    input wire logic IRDY_N,
    output logic DEVSEL_N_O,
    output logic DEVSEL_OE_N,
    output logic FW_DATA_VALID,
    // Error and interrupt pins
    output logic SERR_N_O,
    output logic SERR_OE_N,
    output logic INTA_N_O,
    output logic INTA_OE_N,
    output logic INTB_N_O,
    output logic INTB_OE_N,
    // Configuration select to the PCI target logic
    output logic CFG_SEL,
    // User request side
    input wire logic REQ_VALID,
    input wire logic [3:0] REQ_CMD,
    input wire logic [31:0] REQ_ADDR,
    output logic REQ_READY,
    // User write data side
    input wire logic [31:0] WR_DATA,
    input wire logic [3:0] WR_BE,
    output logic WR_TAKE,
    // User read data side
    output logic [31:0] RD_DATA,
    output logic RD_VALID,
    output logic RD_HP,
    // Fast-write stall, error and interrupt controls
    input wire logic FW_STALL,
    input wire logic SERR_SUPPORTED,
    input wire logic FATAL_ERR,
    input wire logic [1:0] INT_SRC
);
    typedef struct packed {
        gpsr_pkg::gpsr_state_type state;
        logic [2:0] cnt;
        logic req_n;
        logic [31:0] ad_o;
        logic ad_oe_n;
        logic [3:0] cbe_o;
        logic cbe_oe_n;
        logic pipe_n;
        logic par_o;
        logic par_oe_n;
        logic [31:0] rd_data;
        logic rd_valid;
        logic rd_hp;
        logic serr_n;
        logic devsel_n;
        logic inta_n;
        logic intb_n;
    } gpsr_core_type;

    localparam logic [2:0] LAST_BEAT = 3'(BEATS - 1);

    gpsr_core_type cur_ff, nxt_ff;
    gpsr_gnt_if gi ();

    // Grant decode lives in its own module
    gpsr_gnt_decode u_dec (
        .clk(CLK),
        .srst(SRST),
        .gnt_n(GNT_N),
        .grant_type_code(GRANT_TYPE_CODE),
        .gi(gi)
    );

    // Sequencer and pin drivers in one next-state process
    always_comb
    begin
        nxt_ff = cur_ff;
        nxt_ff.rd_valid = 1'b0;
        nxt_ff.pipe_n = gpsr_pkg::IDLE_HIGH;
        // Parity follows the bus owner one clock behind
        nxt_ff.par_o = ^{cur_ff.ad_o, cur_ff.cbe_o};
        nxt_ff.par_oe_n = cur_ff.ad_oe_n;
        unique case (cur_ff.state)
            gpsr_pkg::ST_IDLE:
            begin
                nxt_ff.ad_oe_n = gpsr_pkg::IDLE_HIGH;
                nxt_ff.cbe_oe_n = gpsr_pkg::IDLE_HIGH;
                if (gi.gnt_write)
                    nxt_ff.state = gpsr_pkg::ST_WDAT;
                else if (gi.gnt_read)
                    nxt_ff.state = gpsr_pkg::ST_RDAT;
                else if (REQ_VALID)
                begin
                    nxt_ff.req_n = 1'b0;
                    nxt_ff.state = gpsr_pkg::ST_REQ;
                end
            end
            gpsr_pkg::ST_REQ:
            begin
                if (gi.gnt_start)
                begin
                    // Enqueue cycle: address on AD, port command on C/BE
                    nxt_ff.req_n = gpsr_pkg::IDLE_HIGH;
                    nxt_ff.pipe_n = 1'b0;
                    nxt_ff.ad_o = REQ_ADDR;
                    nxt_ff.ad_oe_n = 1'b0;
                    nxt_ff.cbe_o = REQ_CMD;
                    nxt_ff.cbe_oe_n = 1'b0;
                    nxt_ff.state = gpsr_pkg::ST_ENQ;
                end
                else if (gi.gnt_write)
                    nxt_ff.state = gpsr_pkg::ST_WDAT;
                else if (gi.gnt_read)
                    nxt_ff.state = gpsr_pkg::ST_RDAT;
            end
            gpsr_pkg::ST_ENQ:
            begin
                nxt_ff.ad_oe_n = gpsr_pkg::IDLE_HIGH;
                nxt_ff.cbe_oe_n = gpsr_pkg::IDLE_HIGH;
                nxt_ff.state = gpsr_pkg::ST_IDLE;
            end
            gpsr_pkg::ST_WDAT:
            begin
                // Each beat drives data with its byte enables
                nxt_ff.ad_o = WR_DATA;
                nxt_ff.ad_oe_n = 1'b0;
                nxt_ff.cbe_o = WR_BE;
                nxt_ff.cbe_oe_n = 1'b0;
                nxt_ff.cnt = cur_ff.cnt + 3'h1;
                if (cur_ff.cnt == LAST_BEAT)
                begin
                    nxt_ff.cnt = gpsr_pkg::CNT_RST;
                    nxt_ff.state = gpsr_pkg::ST_ENQ;
                end
            end
            gpsr_pkg::ST_RDAT:
            begin
                // Target owns C/BE with zeros; their value is ignored
                nxt_ff.ad_oe_n = gpsr_pkg::IDLE_HIGH;
                nxt_ff.cbe_oe_n = gpsr_pkg::IDLE_HIGH;
                nxt_ff.rd_data = AD_I;
                nxt_ff.rd_valid = 1'b1;
                nxt_ff.rd_hp = gi.gnt_hp | cur_ff.rd_hp;
                nxt_ff.cnt = cur_ff.cnt + 3'h1;
                if (cur_ff.cnt == LAST_BEAT)
                begin
                    nxt_ff.cnt = gpsr_pkg::CNT_RST;
                    nxt_ff.state = cur_ff.req_n ? gpsr_pkg::ST_IDLE
                        : gpsr_pkg::ST_REQ;
                end
            end
        endcase
        if (cur_ff.state != gpsr_pkg::ST_RDAT)
            nxt_ff.rd_hp = gi.gnt_hp;
        // Fast-write stall only inside a core-driven frame
        nxt_ff.devsel_n = ~(~FRAME_N & FW_STALL);
        // Error held one clock behind each faulted cycle, only where the core has the line
        nxt_ff.serr_n = ~(FATAL_ERR & SERR_SUPPORTED);
        // Level interrupts; second function only when present
        nxt_ff.inta_n = ~INT_SRC[0];
        nxt_ff.intb_n = ~(INT_SRC[1] & (TWO_FUNC != 0));
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            cur_ff <= '0;
            cur_ff.state <= gpsr_pkg::ST_IDLE;
            cur_ff.cnt <= gpsr_pkg::CNT_RST;
            cur_ff.req_n <= gpsr_pkg::IDLE_HIGH;
            cur_ff.ad_o <= gpsr_pkg::AD_RST;
            cur_ff.ad_oe_n <= gpsr_pkg::IDLE_HIGH;
            cur_ff.cbe_o <= gpsr_pkg::CBE_RST;
            cur_ff.cbe_oe_n <= gpsr_pkg::IDLE_HIGH;
            cur_ff.pipe_n <= gpsr_pkg::IDLE_HIGH;
            cur_ff.par_oe_n <= gpsr_pkg::IDLE_HIGH;
            cur_ff.serr_n <= gpsr_pkg::IDLE_HIGH;
            cur_ff.devsel_n <= gpsr_pkg::IDLE_HIGH;
            cur_ff.inta_n <= gpsr_pkg::IDLE_HIGH;
            cur_ff.intb_n <= gpsr_pkg::IDLE_HIGH;
        end
        else
            cur_ff <= nxt_ff;
    end

    // Pin outputs; open-drain lines only enabled while pulling low
    assign REQ_N = cur_ff.req_n;
    assign AD_O = cur_ff.ad_o;
    assign AD_OE_N = cur_ff.ad_oe_n;
    assign CBE_O = cur_ff.cbe_o;
    assign CBE_OE_N = cur_ff.cbe_oe_n;
    assign PAR_O = cur_ff.par_o;
    assign PAR_OE_N = cur_ff.par_oe_n;
    assign PIPE_N = cur_ff.pipe_n;
    assign DEVSEL_N_O = cur_ff.devsel_n;
    assign DEVSEL_OE_N = cur_ff.devsel_n;
    assign SERR_N_O = 1'b0;
    assign SERR_OE_N = cur_ff.serr_n;
    assign INTA_N_O = 1'b0;
    assign INTA_OE_N = cur_ff.inta_n;
    assign INTB_N_O = 1'b0;
    assign INTB_OE_N = cur_ff.intb_n;
    // No lock pin, no third or fourth interrupt line
    // Core marks fast-write data valid with initiator-ready
    assign FW_DATA_VALID = ~FRAME_N & ~IRDY_N;
    // Select for the mandatory PCI target, taken from the address bus
    assign CFG_SEL = AD_I[gpsr_pkg::CFG_SEL_BIT];
    assign REQ_READY = (cur_ff.state == gpsr_pkg::ST_REQ) & gi.gnt_start;
    assign WR_TAKE = (cur_ff.state == gpsr_pkg::ST_WDAT);
    assign RD_DATA = cur_ff.rd_data;
    assign RD_VALID = cur_ff.rd_valid;
    assign RD_HP = cur_ff.rd_hp;

    sequence s_start_grant;
        cur_ff.state == gpsr_pkg::ST_REQ && gi.gnt_start;
    endsequence
    sequence s_enqueue;
        !PIPE_N && !CBE_OE_N && REQ_N;
    endsequence

    a_req_before_enq: assert property (@(posedge CLK) disable iff (SRST)
        $fell(PIPE_N) |-> !$past(REQ_N))
        else $error("enqueue without prior request");
    a_enq_cmd_driven: assert property (@(posedge CLK) disable iff (SRST)
        s_start_grant |=> s_enqueue ##1 PIPE_N)
        else $error("enqueue cycle wrong");
    a_enq_cmd_value: assert property (@(posedge CLK) disable iff (SRST)
        s_start_grant |=> CBE_O == $past(REQ_CMD))
        else $error("command not placed on C/BE");
    a_write_be: assert property (@(posedge CLK) disable iff (SRST)
        WR_TAKE |=> !CBE_OE_N && CBE_O == $past(WR_BE))
        else $error("write byte enables wrong");
    a_read_no_cbe: assert property (@(posedge CLK) disable iff (SRST)
        RD_VALID |-> CBE_OE_N && AD_OE_N)
        else $error("device drove bus during read return");
    a_par_owner: assert property (@(posedge CLK) disable iff (SRST)
        !AD_OE_N |=> !PAR_OE_N && PAR_O == ^{$past(AD_O), $past(CBE_O)})
        else $error("parity not driven by owner");
    a_serr_gated: assert property (@(posedge CLK) disable iff (SRST)
        !SERR_OE_N |-> $past(FATAL_ERR) && $past(SERR_SUPPORTED))
        else $error("error line without support");
    a_intb_unused: assert property (@(posedge CLK) disable iff (SRST)
        !INTB_OE_N |-> (TWO_FUNC != 0) && $past(INT_SRC[1]))
        else $error("second interrupt used by single function");
    a_devsel_idle: assert property (@(posedge CLK) disable iff (SRST)
        $past(FRAME_N) |-> DEVSEL_OE_N)
        else $error("device-select outside fast-write");
    a_read_block: assert property (@(posedge CLK) disable iff (SRST)
        $rose(cur_ff.state == gpsr_pkg::ST_RDAT) |=> RD_VALID [*4])
        else $error("read block length wrong");
endmodule

// ### verif/gpsr_core_model.sv
// Core-logic partner: arbiter, read-data source and fast-write initiator.
// Assumes it shares CLK and SRST with the graphics-side port logic.
`timescale 1ns/1ps
module gpsr_core_model #(
    parameter int BEATS = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Port pins seen from the core side
    input wire logic req_n,
    output logic gnt_n,
    output logic [2:0] gtc,
    output logic [31:0] ad,
    output logic [3:0] cbe_ret,
    output logic frame_n,
    output logic irdy_n,
    output logic tgt_idle_n,
    // Bench commands
    input wire logic go,
    input wire logic [2:0] code,
    input wire logic fw_go,
    input wire logic [1:0] lat,
    input wire logic [31:0] rd_base
);
    int wcnt;
    int rb;
    int fwc;
    int seed = 51;
    logic armed;
    // Known pin levels before the first reset edge
    initial
    begin
        gnt_n = 1'b1;
        gtc = 3'h0;
        ad = 32'h0000_0000;
        frame_n = 1'b1;
        irdy_n = 1'b1;
    end
    // Select, parity error and lock lines stay idle
    assign tgt_idle_n = 1'b1;
    // Command lines forced to zero while returning reads
    assign cbe_ret = (rb >= 2) ? 4'h0 : 4'hf;
    // Arbiter, read return and fast-write framing
    always @(posedge clk)
    begin
        gnt_n <= 1'b1;
        gtc <= 3'($random(seed)); // Junk code while not granting
        ad <= ~ad; // Released bus never keeps its last value
        if (srst)
        begin
            armed <= 1'b1;
            wcnt <= 0;
            rb <= 0;
            fwc <= 0;
            frame_n <= 1'b1;
            irdy_n <= 1'b1;
        end
        else
        begin
            if (rb >= 2)
                ad <= rd_base + 32'(rb - 2) * 32'h0101_0101;
            if (rb != 0)
                rb <= (rb == BEATS + 1) ? 0 : rb + 1;
            if (go)
            begin
                gnt_n <= 1'b0;
                gtc <= code;
                rb <= (code <= 3'h1) ? 1 : 0;
            end
            else if (!req_n && armed)
            begin
                // Start is granted only to a pending request
                if (wcnt >= int'(lat))
                begin
                    gnt_n <= 1'b0;
                    gtc <= 3'h7;
                    armed <= 1'b0;
                    wcnt <= 0;
                end
                else
                    wcnt <= wcnt + 1;
            end
            if (req_n)
                armed <= 1'b1;
            // One block with no wait states inside it
            if (fw_go)
                fwc <= BEATS;
            else if (fwc != 0)
                fwc <= fwc - 1;
            frame_n <= !(fw_go || fwc > 1);
            irdy_n <= !(fw_go || fwc > 1);
        end
    end
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the graphics-side port signal logic.
// Assumes the core-logic partner model drives grant, bus and frame.
`timescale 1ns/1ps
module tb_top;
    localparam int BEATS = 4;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic REQ_N, GNT_N, AD_OE_N, CBE_OE_N, PAR_O, PAR_OE_N, PIPE_N;
    logic [2:0] GRANT_TYPE_CODE;
    logic [31:0] AD_I, AD_O, REQ_ADDR, WR_DATA, RD_DATA;
    logic [3:0] CBE_O, REQ_CMD, WR_BE;
    logic FRAME_N, IRDY_N, DEVSEL_N_O, DEVSEL_OE_N, FW_DATA_VALID;
    logic SERR_N_O, SERR_OE_N, INTA_N_O, INTA_OE_N, INTB_N_O, INTB_OE_N;
    logic CFG_SEL, REQ_VALID, REQ_READY, WR_TAKE, RD_VALID, RD_HP;
    logic FW_STALL, SERR_SUPPORTED, FATAL_ERR;
    logic [1:0] INT_SRC, lat;
    logic go, fw_go;
    logic [2:0] code;
    logic [31:0] rd_base;
    int seed = 51;
    int err_count = 0;
    int checks_done = 0;
    int ev_cnt = 0;
    int rd_cnt = 0;
    int wr_cnt = 0;
    int cyc = 0;
    logic s_srst, s_rv, s_wt, s_aoe, s_fe, s_st;
    logic [31:0] s_addr, s_wd, s_adi, s_ado;
    logic [3:0] s_cmd, s_be, s_cbe;
    logic [1:0] s_int;
    logic hp_seen;

    gpsr_port_ctrl #(.TWO_FUNC(1), .BEATS(BEATS)) u_dut (.CLK(CLK),
        .SRST(SRST), .REQ_N(REQ_N), .GNT_N(GNT_N),
        .GRANT_TYPE_CODE(GRANT_TYPE_CODE), .AD_I(AD_I), .AD_O(AD_O),
        .AD_OE_N(AD_OE_N), .CBE_O(CBE_O), .CBE_OE_N(CBE_OE_N),
        .PAR_O(PAR_O), .PAR_OE_N(PAR_OE_N), .PIPE_N(PIPE_N),
        .FRAME_N(FRAME_N), .IRDY_N(IRDY_N), .DEVSEL_N_O(DEVSEL_N_O),
        .DEVSEL_OE_N(DEVSEL_OE_N), .FW_DATA_VALID(FW_DATA_VALID),
        .SERR_N_O(SERR_N_O), .SERR_OE_N(SERR_OE_N), .INTA_N_O(INTA_N_O),
        .INTA_OE_N(INTA_OE_N), .INTB_N_O(INTB_N_O), .INTB_OE_N(INTB_OE_N),
        .CFG_SEL(CFG_SEL), .REQ_VALID(REQ_VALID), .REQ_CMD(REQ_CMD),
        .REQ_ADDR(REQ_ADDR), .REQ_READY(REQ_READY), .WR_DATA(WR_DATA),
        .WR_BE(WR_BE), .WR_TAKE(WR_TAKE), .RD_DATA(RD_DATA),
        .RD_VALID(RD_VALID), .RD_HP(RD_HP), .FW_STALL(FW_STALL),
        .SERR_SUPPORTED(SERR_SUPPORTED), .FATAL_ERR(FATAL_ERR),
        .INT_SRC(INT_SRC));

    gpsr_core_model #(.BEATS(BEATS)) u_core (.clk(CLK), .srst(SRST),
        .req_n(REQ_N), .gnt_n(GNT_N), .gtc(GRANT_TYPE_CODE), .ad(AD_I),
        .cbe_ret(), .frame_n(FRAME_N), .irdy_n(IRDY_N), .tgt_idle_n(),
        .go(go), .code(code), .fw_go(fw_go), .lat(lat), .rd_base(rd_base));

    // 125 MHz clock
    always #4 CLK = ~CLK;

    // Wide enough for read data plus its two enables
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
        input string nm);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic [31:0] rd_exp(input int i);
        return rd_base + 32'(i) * 32'h0101_0101;
    endfunction

    // Random side inputs every falling edge
    always @(negedge CLK)
    begin
        INT_SRC = 2'($random(seed));
        FATAL_ERR = 1'($random(seed));
        SERR_SUPPORTED = 1'($random(seed));
        FW_STALL = 1'($random(seed));
        WR_DATA = $random(seed);
        WR_BE = 4'($random(seed));
    end

    // Monitor: inputs before the edge, outputs just after it
    always @(posedge CLK)
    begin
        {s_srst, s_rv, s_addr, s_cmd} = {SRST, REQ_READY, REQ_ADDR, REQ_CMD};
        {s_wt, s_wd, s_be, s_adi} = {WR_TAKE, WR_DATA, WR_BE, AD_I};
        {s_ado, s_cbe, s_aoe, s_int} = {AD_O, CBE_O, AD_OE_N, INT_SRC};
        s_fe = FATAL_ERR & SERR_SUPPORTED;
        s_st = !FRAME_N & FW_STALL;
        #1;
        if (s_srst)
        begin
            chk({REQ_N, PIPE_N, AD_OE_N, CBE_OE_N}, 4'hf, "reset lines");
            chk(RD_VALID, 1'b0, "reset rd valid");
        end
        else
        begin
            if (s_rv | s_wt | RD_VALID | !PIPE_N)
                ev_cnt++;
            if (s_rv)
                chk({PIPE_N, AD_OE_N, CBE_O}, {2'h0, s_cmd}, "enqueue");
            if (s_rv)
                chk(AD_O, s_addr, "enqueue addr");
            if (s_wt)
                chk({AD_OE_N, CBE_OE_N, CBE_O}, {2'h0, s_be}, "write be");
            if (s_wt)
                chk(AD_O, s_wd, "write data");
            wr_cnt += s_wt;
            if (!s_aoe)
                chk({PAR_OE_N, PAR_O}, {1'b0, ^{s_ado, s_cbe}}, "par");
            if (RD_VALID)
                chk({RD_DATA, AD_OE_N, CBE_OE_N}, {s_adi, 2'h3}, "rd");
            rd_cnt += RD_VALID;
            // Priority flag only means something beside a read beat
            if (RD_VALID)
                hp_seen = RD_HP;
            chk({INTB_OE_N, INTA_OE_N}, {~s_int}, "int enables");
            chk({INTA_N_O, INTB_N_O}, 2'h0, "int level");
            chk({SERR_OE_N, SERR_N_O}, {~s_fe, 1'b0}, "serr");
            chk({DEVSEL_N_O, DEVSEL_OE_N}, {2{~s_st}}, "devsel stall");
            chk(CFG_SEL, AD_I[16], "cfg select");
            chk(FW_DATA_VALID, !FRAME_N & !IRDY_N, "fw valid");
        end
    end

    // Hang guard
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            finish_test();
        end
    end

    task automatic enq();
        int n;
        n = 0;
        @(negedge CLK);
        REQ_VALID = 1'b1;
        REQ_ADDR = $random(seed);
        REQ_CMD = 4'($random(seed));
        lat = 2'($random(seed));
        // Ready is looked at mid-cycle, where it is settled
        while (REQ_READY !== 1'b1 && n < 40)
        begin
            @(negedge CLK);
            n++;
        end
        chk(REQ_N, 1'b0, "request held");
        chk(n < 40, 1'b1, "request taken");
        @(negedge CLK);
        REQ_VALID = 1'b0;
        repeat (3) @(negedge CLK);
    endtask

    task automatic grant(input logic [2:0] c);
        int e0;
        int r0;
        int w0;
        {e0, r0, w0} = {ev_cnt, rd_cnt, wr_cnt};
        hp_seen = ~c[0];
        @(negedge CLK);
        go = 1'b1;
        code = c;
        rd_base = $random(seed);
        @(negedge CLK);
        go = 1'b0;
        repeat (BEATS + 4) @(negedge CLK);
        if (c <= 3'h1)
        begin
            chk(32'(rd_cnt - r0), BEATS, "read beats");
            chk(RD_DATA, rd_exp(BEATS - 1), "read last");
            chk(hp_seen, c[0], "read priority");
        end
        else if (c <= 3'h3)
            chk(32'(wr_cnt - w0), BEATS, "write beats");
        else
            chk(32'(ev_cnt - e0), 0, "reserved code");
    endtask

    // Main sequence
    initial
    begin
        {REQ_VALID, REQ_CMD, REQ_ADDR, go, code, fw_go, lat} = '0;
        rd_base = 32'h0000_0000;
        repeat (6) @(negedge CLK);
        SRST = 1'b0;
        repeat (8) enq();
        for (int c = 0; c < 7; c++)
            grant(3'(c));
        repeat (3)
        begin
            @(negedge CLK);
            fw_go = 1'b1;
            @(negedge CLK);
            fw_go = 1'b0;
            repeat (BEATS + 3) @(negedge CLK);
        end
        enq();
        grant(3'h3);
        grant(3'h1);
        finish_test();
    end
endmodule
